// ---- core/ism_defines.svh ----
// Constants for the two-wire slave memory front end: addresses, offsets, timing.
// Assumes it is included by the package and the top module by bare name.
// Notes on behaviour
// - Start is data falling while clock high; stop is data rising while clock high.
// - Incoming bits are sampled on clock rise; data line changes only while clock low.
// - Outgoing bits are driven after the preceding clock fall, valid at next rise.
// - Receiver drives ninth bit low to acknowledge, leaves it high to refuse.
// - Each byte is eight bits, most significant first, then one acknowledge bit.
// - First byte after start holds 7-bit slave address and direction in bit zero.
// - Auxiliary memory answers at slave address A0h unless the main address disables it.
// - Programmed main address equal to A0h or B0h disables auxiliary memory.
// - Main space answers the programmed address, within A0h-AEh or B0h-BEh; the code takes any programmed value, with bit zero cleared.
// - Programmed main address applies only while source select is set.
// - Direction flag zero means master writes; one means master reads.
// - On address mismatch, stay off the bus until the next start.
// - In a write, the byte after the slave address loads the address counter.
// - One to eight data bytes per write, stored at successive counter addresses.
// - Write counter stays inside the current 8-byte row, wrapping to its start.
// - After stop ending a page write, refuse slave address until programming ends.
// - Programming rewrites the whole page, keeping bytes not written.
// - In shadow mode, writes touch volatile storage only and start no programming.
// - Reads return data from the current counter without a memory address byte.
// - Write of memory address then repeated start and read honours the pointer.
// - Keep sending while master acknowledges; release data once it refuses.
// - Main address is A2h until the programmed address is recalled.
// - Second main space answers at the main address with bit 4 set, B2h by default.
// - In shadow mode shadowed cells write without limit and without delay.
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH

`define ISM_AUX_ADDR 8'hA0
`define ISM_ALT_AUX_ADDR 8'hB0
`define ISM_DEFAULT_MAIN 8'hA2
`define ISM_DEVADDR_OFFSET 8'h8B
`define ISM_SECOND_BIT 4
`define ISM_ROW_BITS 3
`define ISM_BYTE_BITS 4'h8
`define ISM_ACK_END 4'h9
`define ISM_CLOCK_NS 100
`define ISM_PROG_TIME_NS 10000000

`endif

// ---- core/ism_pkg.sv ----
// Types shared by the two-wire slave memory front end.
// Assumes the defines header sits beside it.
`include "ism_defines.svh"

package ism_pkg;

  // Which memory space a slave address selected
  typedef enum logic [1:0] {
    sp_aux,
    sp_main1,
    sp_main2
  } ism_space_e;

  // Bus-side sequencing
  typedef enum logic [1:0] {
    st_idle,
    st_rx,
    st_tx,
    st_ignore
  } ism_state_e;

  // Meaning of the byte now being received
  typedef enum logic [1:0] {
    k_slave,
    k_memaddr,
    k_data
  } ism_kind_e;

  // One byte written into a memory space
  typedef struct packed {
    ism_space_e space;
    logic volatile_only;
    logic [7:0] addr;
    logic [7:0] data;
  } ism_wr_word_s;

endpackage : ism_pkg

// ---- core/ism_top.sv ----
// Two-wire slave front end giving a bus master byte access to three memory spaces.
// Assumes the memory sits outside on the same clock: reads answer rd_addr combinationally,
// writes drain through a small buffer, and page programming follows prog_start.
`timescale 1ns/1ps
`include "ism_defines.svh"

module ism_top
  import ism_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter int PROG_TIME_NS = `ISM_PROG_TIME_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial pins, open-drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration from the device
  input wire logic main_address_source_select,
  input wire logic shadow_volatile_write_mode,
  input wire logic nv_recalled,
  // Memory write stream
  output logic wr_valid,
  output ism_wr_word_s wr_data,
  input wire logic wr_ready,
  // Memory read port
  output ism_space_e rd_space,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Page programming
  output logic prog_start,
  output ism_space_e prog_space,
  output logic [7:0] prog_row,
  output logic prog_busy
);

  // Least programming wait, rounded up to whole cycles
  localparam int PROG_CYC = (PROG_TIME_NS + `ISM_CLOCK_NS - 1) / `ISM_CLOCK_NS;
  localparam int PW = $clog2(PROG_CYC + 1);

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  ism_state_e state;
  ism_kind_e kind;
  ism_space_e space;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sr, tx_sr, ptr, main_slave_address_select, rd_ld;
  logic [7:0] main_eff, main_two;
  logic aux_en, hit_aux, hit_main1, hit_main2, wrote;
  logic [PW-1:0] prog_cnt;
  logic push, pop, fifo_ready;
  ism_wr_word_s push_word;
  logic [DEPTH-1:0] q_valid, shifted_v;
  ism_wr_word_s q_data [DEPTH];
  ism_wr_word_s shifted_d [DEPTH];

  // Two-stage synchronisers; the master's clock is slow against ours
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  // Edges and bus conditions, seen only after synchronising
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Slave address decode
  always_comb begin
    main_eff = `ISM_DEFAULT_MAIN;
    if (main_address_source_select && nv_recalled) begin
      main_eff = {main_slave_address_select[7:1], 1'b0};
    end
    main_two = main_eff;
    main_two[`ISM_SECOND_BIT] = 1'b1;
    aux_en = (main_eff != `ISM_AUX_ADDR) && (main_eff != `ISM_ALT_AUX_ADDR);
    hit_main1 = rx_sr[7:1] == main_eff[7:1];
    hit_main2 = rx_sr[7:1] == main_two[7:1];
    hit_aux = aux_en && ({rx_sr[7:1], 1'b0} == `ISM_AUX_ADDR);
  end

  // Bytes pushed to memory carry the counter and the shadow choice
  assign push_word = '{space: space, volatile_only: shadow_volatile_write_mode,
                       addr: ptr, data: rx_sr};
  assign push = (state == st_rx) && scl_fall && (bit_cnt == `ISM_BYTE_BITS) &&
                (kind == k_data) && fifo_ready;

  // Bit counter and receive shifter; bits sampled on clock rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'h0;
      rx_sr <= 8'h00;
    end else if (start_det) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && state != st_idle) begin
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt < `ISM_BYTE_BITS) begin
        rx_sr <= {rx_sr[6:0], sda_s2};
      end
    end else if (scl_fall && bit_cnt == `ISM_ACK_END) begin
      bit_cnt <= 4'h0;
    end
  end

  // Transaction sequencing and data line drive; drive changes on clock fall, and is released at start or stop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      kind <= k_slave;
      space <= sp_aux;
      sda_oe <= 1'b0;
      tx_sr <= 8'h00;
    end else if (start_det) begin
      state <= st_rx;
      kind <= k_slave;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= st_idle;
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        st_rx: begin
          if (bit_cnt == `ISM_BYTE_BITS) begin
            case (kind)
              k_slave: begin
                if (!prog_busy && (hit_main1 || hit_main2 || hit_aux)) begin
                  sda_oe <= 1'b1;
                  space <= hit_main1 ? sp_main1 : (hit_main2 ? sp_main2 : sp_aux);
                  kind <= k_memaddr;
                end else begin
                  state <= st_ignore;
                end
              end
              k_memaddr: begin
                sda_oe <= 1'b1;
                kind <= k_data;
              end
              default: begin
                sda_oe <= fifo_ready; // Refusing is how a full buffer stalls the master
                if (!fifo_ready) begin
                  state <= st_ignore;
                end
              end
            endcase
          end else if (bit_cnt == `ISM_ACK_END) begin
            sda_oe <= 1'b0;
            if (kind == k_memaddr && rx_sr[0]) begin
              state <= st_tx;
              tx_sr <= {rd_ld[6:0], 1'b0};
              sda_oe <= ~rd_ld[7];
            end
          end
        end
        st_tx: begin
          if (bit_cnt == `ISM_ACK_END) begin
            tx_sr <= {rd_ld[6:0], 1'b0};
            sda_oe <= ~rd_ld[7];
          end else if (bit_cnt == `ISM_BYTE_BITS) begin
            sda_oe <= 1'b0;
          end else if (bit_cnt != 4'h0) begin
            sda_oe <= ~tx_sr[7];
            tx_sr <= {tx_sr[6:0], 1'b0};
          end
        end
        default: sda_oe <= 1'b0;
      endcase
    end else if (scl_rise && state == st_tx && bit_cnt == `ISM_BYTE_BITS && sda_s2) begin
      state <= st_ignore;
    end
  end

  // Register at the device-address offset answers reads here, not from memory
  assign rd_ld = (space == sp_main1 && ptr == `ISM_DEVADDR_OFFSET) ?
                 main_slave_address_select : rd_data;

  // Address counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr <= 8'h00;
    end else if (state == st_rx && scl_fall && bit_cnt == `ISM_BYTE_BITS &&
                 kind == k_memaddr) begin
      ptr <= rx_sr;
    end else if (push) begin
      ptr <= {ptr[7:`ISM_ROW_BITS], ptr[`ISM_ROW_BITS-1:0] + 3'h1};
    end else if (state == st_tx && scl_rise && bit_cnt == `ISM_BYTE_BITS) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Device-address register, written through the main space
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_slave_address_select <= `ISM_DEFAULT_MAIN;
    end else if (push && space == sp_main1 && ptr == `ISM_DEVADDR_OFFSET) begin
      main_slave_address_select <= rx_sr;
    end
  end

  // Read port follows the counter a cycle later; loads occur much later on clock fall
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_space <= sp_aux;
      rd_addr <= 8'h00;
      sda_out <= 1'b0;
    end else begin
      rd_space <= space;
      rd_addr <= ptr;
      sda_out <= 1'b0;
    end
  end

  // Page programming after stop; shadow mode skips it entirely
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrote <= 1'b0;
      prog_start <= 1'b0;
      prog_space <= sp_aux;
      prog_row <= 8'h00;
      prog_busy <= 1'b0;
      prog_cnt <= '0;
    end else begin
      prog_start <= 1'b0;
      if (start_det) begin
        wrote <= 1'b0;
      end else if (push) begin
        wrote <= 1'b1;
        prog_space <= space;
        prog_row <= {ptr[7:`ISM_ROW_BITS], `ISM_ROW_BITS'(0)};
      end
      if (stop_det && wrote && !shadow_volatile_write_mode) begin
        wrote <= 1'b0;
        prog_start <= 1'b1;
        prog_busy <= 1'b1;
        prog_cnt <= PW'(PROG_CYC);
      end else if (stop_det) begin
        wrote <= 1'b0;
      end else if (prog_busy) begin
        prog_cnt <= prog_cnt - PW'(1);
        if (prog_cnt == PW'(1)) begin
          prog_busy <= 1'b0;
        end
      end
    end
  end

  // Write buffer: head always in entry 0, so the outputs come straight from flops
  assign pop = q_valid[0] & wr_ready;
  assign fifo_ready = ~q_valid[DEPTH-1] | wr_ready;
  assign wr_valid = q_valid[0];
  assign wr_data = q_data[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    if (i == DEPTH - 1) begin : g_last
      assign shifted_v[i] = pop ? 1'b0 : q_valid[i];
      assign shifted_d[i] = q_data[i];
    end else begin : g_mid
      assign shifted_v[i] = pop ? q_valid[i+1] : q_valid[i];
      assign shifted_d[i] = pop ? q_data[i+1] : q_data[i];
    end
    logic prev_full;
    if (i == 0) begin : g_first
      assign prev_full = 1'b1;
    end else begin : g_next
      assign prev_full = shifted_v[i-1];
    end
    // Entry takes the new word if it is the first free slot after the shift
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        q_valid[i] <= 1'b0;
        q_data[i] <= '0;
      end else if (push && prev_full && !shifted_v[i]) begin
        q_valid[i] <= 1'b1;
        q_data[i] <= push_word;
      end else begin
        q_valid[i] <= shifted_v[i];
        q_data[i] <= shifted_d[i];
      end
    end
  end

  // Checks on the sequencing above
  a_idle_off_bus:
  assert property (@(posedge clock) disable iff (rst)
    (state == st_ignore || state == st_idle) && !$past(state == st_rx || state == st_tx)
      |-> !sda_oe)
    else $error("data line driven while off the bus");

  a_drive_clock_low:
  assert property (@(posedge clock) disable iff (rst)
    $changed(sda_oe) && !$past(start_det || stop_det) |-> !$past(scl_s2))
    else $error("data drive changed while clock high");

  a_ack_ninth_bit:
  assert property (@(posedge clock) disable iff (rst)
    sda_oe && state == st_rx |-> bit_cnt == `ISM_BYTE_BITS || bit_cnt == `ISM_ACK_END)
    else $error("receiver drove outside acknowledge bit");

  a_tx_release_ack:
  assert property (@(posedge clock) disable iff (rst)
    state == st_tx && bit_cnt == `ISM_ACK_END |-> !sda_oe)
    else $error("transmitter held data during acknowledge");

  a_busy_refuse:
  assert property (@(posedge clock) disable iff (rst)
    scl_fall && state == st_rx && kind == k_slave && bit_cnt == `ISM_BYTE_BITS && prog_busy
      |=> !sda_oe && state == st_ignore)
    else $error("slave address acknowledged while programming");

  a_row_wrap:
  assert property (@(posedge clock) disable iff (rst)
    push |=> ptr[7:3] == $past(ptr[7:3]) && ptr[2:0] == $past(ptr[2:0]) + 3'h1)
    else $error("write counter left its row");

  a_prog_hold:
  assert property (@(posedge clock) disable iff (rst)
    $rose(prog_busy) |-> prog_busy [*8])
    else $error("programming wait ended too soon");

  a_shadow_no_prog:
  assert property (@(posedge clock) disable iff (rst)
    prog_start |-> !$past(shadow_volatile_write_mode) && $past(stop_det))
    else $error("programming started in shadow mode");

  a_start_restart:
  assert property (@(posedge clock) disable iff (rst)
    start_det |=> state == st_rx && kind == k_slave && bit_cnt == 4'h0 && !sda_oe)
    else $error("start not taken");

  a_read_increment:
  assert property (@(posedge clock) disable iff (rst)
    scl_rise && state == st_tx && bit_cnt == `ISM_BYTE_BITS && !start_det && !stop_det
      |=> ptr == $past(ptr) + 8'h01)
    else $error("read counter did not advance");

endmodule // ism_top

// ---- sim/ism_master.sv ----
// Two-wire bus master model for the slave memory front end.
// Assumes a pulled-up data wire; clock stands high between frames.
`timescale 1ns/1ps

module ism_master (
  // Bench clock, used only to place pin changes just after its rising edge
  input wire logic clock,
  // Bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or repeated start; data released first so it can fall with clock high
  // Aligning here keeps every later pin change off the sampling edge
  task automatic start();
    @(posedge clock);
    #1;
    sda_pull = 1'b0;
    #200 scl = 1'b1;
    #200 sda_pull = 1'b1;
    #200 scl = 1'b0;
    #200;
  endtask

  // Stop: data rises while clock high, then the clock stands still
  task automatic stop();
    sda_pull = 1'b1;
    #200 scl = 1'b1;
    #200 sda_pull = 1'b0;
    #400;
  endtask

  // One bit; long low phase leaves the slave time to release after its acknowledge
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #100 scl = 1'b1;
    #200 r = sda;
    #200 scl = 1'b0;
    #300;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Reads a byte; last one is refused so the slave lets go
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // ism_master

// ---- sim/testbench.sv ----
// Self-checking bench for the two-wire slave memory front end.
// Assumes the master model beside it; memory is modelled here, stalling now and then.
`timescale 1ns/1ps

module testbench;
  import ism_pkg::*;
  localparam int PROG_NS = 20000;
  logic clock, rst, scl, sda_pull, sda, sda_out, sda_oe, take, ack;
  logic src_sel, shadow_mode, recalled, wr_valid, wr_ready, prog_start, prog_busy;
  logic [7:0] rd_addr, rd_data, prog_row, rb;
  logic [7:0] mem [3][256];
  ism_space_e rd_space, prog_space, last_space;
  ism_wr_word_s wr_data, w;
  ism_wr_word_s got[$];
  logic [7:0] last_row;
  int num_errors, checked, cyc, progs, n0;

  // Wired-and data line with pull-up
  assign sda = !(sda_oe || sda_pull);
  assign rd_data = mem[int'(rd_space)][rd_addr];

  ism_top #(.DEPTH(2), .PROG_TIME_NS(PROG_NS)) dut (
    .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .main_address_source_select(src_sel),
    .shadow_volatile_write_mode(shadow_mode), .nv_recalled(recalled),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_space(rd_space), .rd_addr(rd_addr), .rd_data(rd_data),
    .prog_start(prog_start), .prog_space(prog_space), .prog_row(prog_row),
    .prog_busy(prog_busy));
  ism_master m (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda(sda));

  always #50 clock = ~clock;

  // Memory side: sample at the edge, act just after; every fifth cycle stalls
  always @(posedge clock) begin
    take = wr_valid && wr_ready;
    w = wr_data;
    if (prog_start === 1'b1) begin
      progs++;
      last_row = prog_row;
      last_space = prog_space;
    end
    #1;
    cyc++;
    wr_ready = (cyc % 5) != 0;
    if (take) begin
      got.push_back(w);
      mem[int'(w.space)][w.addr] = w.data;
    end
    if (cyc == 30000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Write n bytes base, base+1.. at ma and check the words handed to memory
  task automatic wr_txn(input logic [7:0] sa, input ism_space_e sp, input logic [7:0] ma,
                        input int n, input logic [7:0] base);
    got.delete();
    m.start();
    m.wbyte(sa, ack);
    chk(ack, 1'b1);
    m.wbyte(ma, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.wbyte(base + 8'(i), ack);
      chk(ack, 1'b1);
    end
    m.stop();
    repeat (20) @(posedge clock);
    chk(got.size(), n);
    for (int i = 0; i < n; i++) begin
      chk(got[i], {sp, shadow_mode, ma[7:3], 3'(ma[2:0] + i), base + 8'(i)});
    end
  endtask

  // Read n bytes from ma, setting the pointer by a dummy write when ptr is set
  task automatic rd_txn(input logic [7:0] sa, input ism_space_e sp, input logic ptr,
                        input logic [7:0] ma, input int n);
    m.start();
    if (ptr) begin
      m.wbyte(sa, ack);
      m.wbyte(ma, ack);
      m.start();
    end
    m.wbyte(sa | 8'h01, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, rb);
      chk(rb, mem[int'(sp)][ma + 8'(i)]);
    end
    #300;
    chk(sda_oe, 1'b0);
    m.stop();
  endtask

  // Address only; a refused address must also leave the next byte unanswered
  task automatic probe(input logic [7:0] sa, input logic exp);
    m.start();
    m.wbyte(sa, ack);
    chk(ack, exp);
    m.wbyte(8'h00, ack);
    chk(ack, exp);
    m.stop();
  endtask

  // Wait out page programming under a bound
  task automatic idle();
    int k;
    k = 0;
    while (prog_busy !== 1'b0 && k < 1000) begin
      @(posedge clock);
      k++;
    end
    chk(k < 1000, 1'b1);
  endtask

  task automatic cfg(input logic s, input logic a, input logic r);
    @(posedge clock);
    #1;
    shadow_mode = s;
    src_sel = a;
    recalled = r;
  endtask

  initial begin
    clock = 0;
    rst = 1;
    src_sel = 0;
    shadow_mode = 0;
    recalled = 1;
    wr_ready = 1;
    for (int s = 0; s < 3; s++) begin
      for (int a = 0; a < 256; a++) begin
        mem[s][a] = 8'(a + s) ^ 8'h5A;
      end
    end
    repeat (5) @(posedge clock);
    #1 rst = 0;
    repeat (5) @(posedge clock);
    chk({sda_oe, sda_out, wr_valid, prog_busy}, 4'b0000);
    // Row wrap, page programming and refusal while busy
    wr_txn(8'hA2, sp_main1, 8'h06, 3, 8'h11);
    chk({progs[3:0], last_space, last_row}, {4'h1, sp_main1, 8'h00});
    probe(8'hA2, 1'b0);
    idle();
    rd_txn(8'hA2, sp_main1, 1'b1, 8'h07, 2);
    rd_txn(8'hA2, sp_main1, 1'b0, 8'h09, 1);
    // Auxiliary and second main spaces, full row
    wr_txn(8'hA0, sp_aux, 8'hF0, 1, 8'h77);
    idle();
    rd_txn(8'hA0, sp_aux, 1'b1, 8'hF0, 1);
    wr_txn(8'hB2, sp_main2, 8'h20, 8, 8'h40);
    idle();
    rd_txn(8'hB2, sp_main2, 1'b1, 8'h20, 8);
    probe(8'hA4, 1'b0);
    // Shadow writes start no programming
    cfg(1'b1, 1'b0, 1'b1);
    n0 = progs;
    wr_txn(8'hA2, sp_main1, 8'h30, 2, 8'h55);
    chk({progs == n0, prog_busy}, 2'b10);
    // Programmed main address
    wr_txn(8'hA2, sp_main1, 8'h8B, 1, 8'hA6);
    cfg(1'b1, 1'b1, 1'b1);
    probe(8'hA2, 1'b0);
    probe(8'hA6, 1'b1);
    cfg(1'b1, 1'b1, 1'b0);
    probe(8'hA2, 1'b1);
    cfg(1'b1, 1'b1, 1'b1);
    wr_txn(8'hA6, sp_main1, 8'h8B, 1, 8'hA0);
    wr_txn(8'hA0, sp_main1, 8'h10, 1, 8'h99);
    // Device-address byte reads back the value just programmed
    rd_txn(8'hA0, sp_main1, 1'b1, 8'h8B, 1);
    chk(rb, 8'hA0);
    test_done();
  end
endmodule // testbench
